//--- rtl/raf_filter.sv
// Receive destination-address filter with AHB-Lite register slave.
// Assumes a byte stream from the MAC receiver, least significant bit received first,
// one frame framed by sof on its first byte and eof on its last.
// Behaviour
// RQ1: Compare six address bytes with station bytes one by one; any difference is mismatch.
// RQ2: First received bit is bit 0 of station byte 0; bit 47 is byte 5 bit 7.
// RQ3: Run address through 32-bit CRC; latch top six bits after the 48th bit.
// RQ4: Decode six hash bits to one filter bit; multicast match needs it set.
// RQ5: Filter bit n lives in hash register n/8, bit n mod 8.
// RQ6: Address is multicast when its first received bit is one.
// RQ7: All 48 address bits one gives a broadcast match.
// RQ8: Unicast, multicast, broadcast and final accept indications, each active high.
// RQ9: Software sets all hash bits for every multicast, else only wanted ones.
// RQ10: Accept on unicast, enabled broadcast, enabled multicast, or promiscuous mode.
// RQ11: A rejected frame is discarded and never forwarded.
//
// Implementation choices: the register offsets and the AHB-Lite register port.
module raf_filter (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Incoming frame stream
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_sof,
    input wire logic rx_eof,
    output logic rx_ready,
    // Accepted frame stream
    output logic out_valid,
    output logic [7:0] out_data,
    output logic out_sof,
    output logic out_eof,
    input wire logic out_ready,
    // Per-frame decision
    output logic match_unicast,
    output logic match_multicast,
    output logic match_broadcast,
    output logic final_accept,
    output logic decision_valid
);
    import raf_pkg::*;

    typedef struct packed {
        logic [RAF_NUM_STA-1:0][7:0] station_addr_regs;
        logic [RAF_NUM_HASH-1:0][7:0] group_hash_regs;
        logic accept_all_ones_dest;
        logic accept_group_dest;
        logic accept_every_frame;
        logic dph_rd;
        logic dph_wr;
        logic [5:0] dph_idx;
        logic [31:0] hrdata;
        logic hreadyout;
        raf_state_e fsm;
        logic [2:0] idx;
        logic [RAF_NUM_STA-1:0][7:0] hold;
        logic [31:0] crc;
        logic [5:0] hash;
        logic mismatch;
        logic group_bit;
        logic all_ones;
        logic saw_eof;
        logic [7:0] acc_cnt;
        logic [7:0] rej_cnt;
        logic out_valid;
        logic [7:0] out_data;
        logic out_sof;
        logic out_eof;
        logic m_uni;
        logic m_multi;
        logic m_bcast;
        logic accept;
        logic dec_pulse;
    } raf_filter_s;

    raf_filter_s st;
    raf_filter_s next_st;

    raf_stream_if in_if ();
    raf_stream_if q_if ();

    assign in_if.valid = rx_valid;
    assign in_if.data = rx_data;
    assign in_if.sof = rx_sof;
    assign in_if.eof = rx_eof;

    raf_fifo #(
        .WIDTH(10),
        .DEPTH(RAF_FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .wr(in_if.snk),
        .rd(q_if.src)
    );

    // Serial CRC over one byte, least significant bit first as it left the wire.
    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        logic fb;
        r = c;
        for (int i = 0; i < 8; i++) begin
            fb = r[31] ^ d[i];
            r = {r[30:0], 1'b0} ^ (fb ? RAF_CRC_POLY : 32'h00000000);
        end
        return r;
    endfunction

    logic out_free;
    logic pop;
    logic [31:0] rd_word;
    logic [5:0] a_idx;
    logic a_take;
    logic [7:0] stat_byte;
    logic [5:0] hash_now;
    logic [31:0] crc_now;
    logic mc_hit;

    assign out_free = !st.out_valid || out_ready;
    assign q_if.ready = (st.fsm == RAF_ADDR) || (st.fsm == RAF_DROP)
                        || ((st.fsm == RAF_PASS) && out_free);
    assign pop = q_if.ready && q_if.valid;
    assign a_idx = haddr[7:2];
    assign a_take = hsel && htrans[1] && hready;
    assign crc_now = crc_byte(st.crc, q_if.data);
    assign hash_now = crc_now[RAF_HASH_MSB:RAF_HASH_LSB];
    assign mc_hit = st.group_bit && st.group_hash_regs[st.hash[5:3]][st.hash[2:0]]; // RQ4 RQ5
    assign stat_byte = {4'h0, st.accept, st.m_bcast, st.m_multi, st.m_uni};

    // Read mux, evaluated in the data phase so that a write just before is seen.
    always_comb begin
        rd_word = 32'h00000000;
        for (int i = 0; i < RAF_NUM_STA; i++) begin
            if (st.dph_idx == 6'(RAF_OFS_STATION0[7:2] + i[5:0])) begin
                rd_word = {24'h000000, st.station_addr_regs[i]};
            end
        end
        for (int i = 0; i < RAF_NUM_HASH; i++) begin
            if (st.dph_idx == 6'(RAF_OFS_HASH0[7:2] + i[5:0])) begin
                rd_word = {24'h000000, st.group_hash_regs[i]};
            end
        end
        if (st.dph_idx == RAF_OFS_RX_CONFIG[7:2]) begin
            rd_word[RAF_CFG_ACCEPT_ALL_ONES] = st.accept_all_ones_dest;
            rd_word[RAF_CFG_ACCEPT_GROUP] = st.accept_group_dest;
            rd_word[RAF_CFG_ACCEPT_EVERY] = st.accept_every_frame;
        end
        if (st.dph_idx == RAF_OFS_STATUS[7:2]) begin
            rd_word[7:0] = stat_byte;
            rd_word[RAF_ST_ACC_CNT_LSB +: 8] = st.acc_cnt;
            rd_word[RAF_ST_REJ_CNT_LSB +: 8] = st.rej_cnt;
        end
    end

    always_comb begin
        next_st = st;
        next_st.dec_pulse = 1'b0;

        // Register slave: writes finish with no wait, reads take one wait state.
        next_st.dph_rd = 1'b0;
        next_st.dph_wr = 1'b0;
        next_st.hreadyout = 1'b1;
        if (st.dph_rd) begin
            next_st.hrdata = rd_word;
        end
        if (st.dph_wr) begin
            for (int i = 0; i < RAF_NUM_STA; i++) begin
                if (st.dph_idx == 6'(RAF_OFS_STATION0[7:2] + i[5:0])) begin
                    next_st.station_addr_regs[i] = hwdata[7:0];
                end
            end
            for (int i = 0; i < RAF_NUM_HASH; i++) begin
                if (st.dph_idx == 6'(RAF_OFS_HASH0[7:2] + i[5:0])) begin
                    next_st.group_hash_regs[i] = hwdata[7:0];
                end
            end
            if (st.dph_idx == RAF_OFS_RX_CONFIG[7:2]) begin
                next_st.accept_all_ones_dest = hwdata[RAF_CFG_ACCEPT_ALL_ONES];
                next_st.accept_group_dest = hwdata[RAF_CFG_ACCEPT_GROUP];
                next_st.accept_every_frame = hwdata[RAF_CFG_ACCEPT_EVERY];
            end
        end
        if (a_take) begin
            next_st.dph_idx = a_idx;
            next_st.dph_wr = hwrite;
            next_st.dph_rd = !hwrite;
            next_st.hreadyout = hwrite;
        end

        // Output register drains independently of the state machine.
        if (out_ready) begin
            next_st.out_valid = 1'b0;
        end

        case (st.fsm)
            RAF_ADDR: begin
                if (pop) begin
                    if (q_if.sof || (st.idx == 3'h0)) begin
                        next_st.idx = 3'h0;
                        next_st.hold[0] = q_if.data;
                        next_st.mismatch = (q_if.data != st.station_addr_regs[0]); // RQ1 RQ2
                        next_st.group_bit = q_if.data[0]; // RQ6
                        next_st.all_ones = (q_if.data == RAF_ALL_ONES); // RQ7
                        next_st.crc = crc_byte(RAF_CRC_INIT, q_if.data); // RQ3
                        next_st.idx = 3'h1;
                    end else begin
                        next_st.hold[st.idx] = q_if.data;
                        next_st.mismatch = st.mismatch
                            || (q_if.data != st.station_addr_regs[st.idx]); // RQ1 RQ2
                        next_st.all_ones = st.all_ones && (q_if.data == RAF_ALL_ONES); // RQ7
                        next_st.crc = crc_now; // RQ3
                        next_st.idx = st.idx + 3'h1;
                        if (st.idx == 3'(RAF_NUM_STA - 1)) begin
                            next_st.hash = hash_now; // RQ3
                            next_st.saw_eof = q_if.eof;
                            next_st.idx = 3'h0;
                            next_st.fsm = RAF_DECIDE;
                        end
                    end
                    // A frame too short to hold an address is dropped on its end byte.
                    if (q_if.eof && (next_st.fsm == RAF_ADDR)) begin
                        next_st.idx = 3'h0;
                        next_st.rej_cnt = st.rej_cnt + 8'h01;
                    end
                end
            end
            RAF_DECIDE: begin
                next_st.m_uni = !st.mismatch; // RQ8
                next_st.m_multi = mc_hit; // RQ8
                next_st.m_bcast = st.all_ones; // RQ8
                next_st.accept = !st.mismatch
                    || (st.accept_all_ones_dest && st.all_ones)
                    || (st.accept_group_dest && mc_hit)
                    || st.accept_every_frame; // RQ10
                next_st.dec_pulse = 1'b1;
                if (next_st.accept) begin
                    next_st.acc_cnt = st.acc_cnt + 8'h01;
                    next_st.fsm = RAF_REPLAY;
                end else begin
                    next_st.rej_cnt = st.rej_cnt + 8'h01;
                    next_st.fsm = st.saw_eof ? RAF_ADDR : RAF_DROP; // RQ11
                end
            end
            RAF_REPLAY: begin
                if (out_free) begin
                    next_st.out_valid = 1'b1;
                    next_st.out_data = st.hold[st.idx];
                    next_st.out_sof = (st.idx == 3'h0);
                    next_st.out_eof = (st.idx == 3'(RAF_NUM_STA - 1)) && st.saw_eof;
                    next_st.idx = st.idx + 3'h1;
                    if (st.idx == 3'(RAF_NUM_STA - 1)) begin
                        next_st.idx = 3'h0;
                        next_st.fsm = st.saw_eof ? RAF_ADDR : RAF_PASS;
                    end
                end
            end
            RAF_PASS: begin
                if (pop) begin
                    next_st.out_valid = 1'b1;
                    next_st.out_data = q_if.data;
                    next_st.out_sof = 1'b0;
                    next_st.out_eof = q_if.eof;
                    if (q_if.eof) begin
                        next_st.fsm = RAF_ADDR;
                    end
                end
            end
            RAF_DROP: begin
                // Rejected bytes are pulled and thrown away so the FIFO keeps moving.
                if (pop && q_if.eof) begin
                    next_st.fsm = RAF_ADDR; // RQ11
                end
            end
            default: begin
                next_st.fsm = RAF_ADDR;
                next_st.idx = 3'h0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '{
                station_addr_regs: {RAF_NUM_STA{RAF_RST_STATION}},
                group_hash_regs: {RAF_NUM_HASH{RAF_RST_HASH}},
                accept_all_ones_dest: RAF_RST_RX_CONFIG[RAF_CFG_ACCEPT_ALL_ONES],
                accept_group_dest: RAF_RST_RX_CONFIG[RAF_CFG_ACCEPT_GROUP],
                accept_every_frame: RAF_RST_RX_CONFIG[RAF_CFG_ACCEPT_EVERY],
                hreadyout: 1'b1,
                fsm: RAF_ADDR,
                crc: RAF_CRC_INIT,
                default: '0
            };
        end else begin
            st <= next_st;
        end
    end

    assign hrdata = st.hrdata;
    assign hreadyout = st.hreadyout;
    assign hresp = 1'b0;
    // The fifo's own not-full flop, so a byte offered while ready is high is always taken once.
    assign rx_ready = in_if.ready;
    assign out_valid = st.out_valid;
    assign out_data = st.out_data;
    assign out_sof = st.out_sof;
    assign out_eof = st.out_eof;
    assign match_unicast = st.m_uni;
    assign match_multicast = st.m_multi;
    assign match_broadcast = st.m_bcast;
    assign final_accept = st.accept;
    assign decision_valid = st.dec_pulse;
endmodule

//--- rtl/raf_pkg.sv
// Package of the receive destination-address filter: register map, field positions,
// reset values and the CRC constants.
// Assumes a 32-bit AHB-Lite register bus with one aligned word per register.
package raf_pkg;
    localparam int unsigned RAF_NUM_STA = 6;
    localparam int unsigned RAF_NUM_HASH = 8;
    localparam int unsigned RAF_ADDR_W = 8;

    // Byte addresses; station bytes and hash bytes each sit at consecutive words.
    localparam logic [7:0] RAF_OFS_STATION0 = 8'h00;
    localparam logic [7:0] RAF_OFS_HASH0 = 8'h18;
    localparam logic [7:0] RAF_OFS_RX_CONFIG = 8'h38;
    localparam logic [7:0] RAF_OFS_STATUS = 8'h3c;

    // Receive-configuration fields.
    localparam int unsigned RAF_CFG_ACCEPT_ALL_ONES = 0;
    localparam int unsigned RAF_CFG_ACCEPT_GROUP = 1;
    localparam int unsigned RAF_CFG_ACCEPT_EVERY = 2;

    // Status fields.
    localparam int unsigned RAF_ST_UNICAST = 0;
    localparam int unsigned RAF_ST_MULTICAST = 1;
    localparam int unsigned RAF_ST_BROADCAST = 2;
    localparam int unsigned RAF_ST_ACCEPT = 3;
    localparam int unsigned RAF_ST_ACC_CNT_LSB = 8;
    localparam int unsigned RAF_ST_REJ_CNT_LSB = 16;

    // Reset values.
    localparam logic [7:0] RAF_RST_STATION = 8'h00;
    localparam logic [7:0] RAF_RST_HASH = 8'h00;
    localparam logic [2:0] RAF_RST_RX_CONFIG = 3'h0;

    // Frame-check CRC generator.
    localparam logic [31:0] RAF_CRC_POLY = 32'h04c11db7;
    localparam logic [31:0] RAF_CRC_INIT = 32'hffffffff;
    localparam int unsigned RAF_HASH_MSB = 31;
    localparam int unsigned RAF_HASH_LSB = 26;

    localparam logic [7:0] RAF_ALL_ONES = 8'hff;
    localparam int unsigned RAF_FIFO_DEPTH = 4;

    typedef enum logic [2:0] {
        RAF_ADDR,
        RAF_DECIDE,
        RAF_REPLAY,
        RAF_PASS,
        RAF_DROP
    } raf_state_e;
endpackage

//--- rtl/raf_stream_if.sv
// Byte stream carrier between the filter and its receive FIFO.
// Assumes valid/ready handshake: a byte moves on an edge where both are high.
interface raf_stream_if;
    logic valid;
    logic ready;
    logic [7:0] data;
    logic sof;
    logic eof;

    modport src (output valid, output data, output sof, output eof, input ready);
    modport snk (input valid, input data, input sof, input eof, output ready);
endinterface

//--- rtl/raf_fifo.sv
// Small flop-based FIFO for the received byte stream.
// Assumes a single clock; ready on the filling side is a registered not-full flag.
module raf_fifo #(
    parameter int unsigned WIDTH = 10,
    parameter int unsigned DEPTH = 4
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Streams
    raf_stream_if.snk wr,
    raf_stream_if.src rd
);
    localparam int unsigned PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0] cnt;
        logic not_full;
    } raf_fifo_s;

    raf_fifo_s st;
    raf_fifo_s next_st;
    logic push;
    logic pop;

    assign push = wr.valid && st.not_full;
    assign pop = rd.ready && (st.cnt != '0);
    assign wr.ready = st.not_full;
    assign rd.valid = (st.cnt != '0);
    assign {rd.sof, rd.eof, rd.data} = st.mem[st.rp];

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wp] = {wr.sof, wr.eof, wr.data};
            next_st.wp = (st.wp == PW'(DEPTH - 1)) ? '0 : st.wp + 1'b1;
        end
        if (pop) begin
            next_st.rp = (st.rp == PW'(DEPTH - 1)) ? '0 : st.rp + 1'b1;
        end
        next_st.cnt = st.cnt + (PW+1)'(push) - (PW+1)'(pop);
        next_st.not_full = (next_st.cnt != (PW+1)'(DEPTH));
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '{default: '0, not_full: 1'b1};
        end else begin
            st <= next_st;
        end
    end
endmodule

//--- tb/raf_filter_checker.sv
// Concurrent checks on the ports of the receive address filter.
// Assumes whole-word bus writes and a frame source that waits for ready on each byte.
module raf_filter_checker
    import raf_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Register bus
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    // Streams and decision
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_sof,
    input wire logic rx_ready,
    input wire logic out_valid,
    input wire logic out_sof,
    input wire logic match_unicast,
    input wire logic match_multicast,
    input wire logic match_broadcast,
    input wire logic final_accept,
    input wire logic decision_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sh [16];
    logic wp, eq, ones, grp, uni_q, bro_q, grp_q;
    logic [3:0] wa;
    logic [2:0] cnt, k;
    wire logic [2:0] cfg = sh[14][2:0];
    // Address results are frozen at the sixth byte so that the next frame cannot disturb them.
    always_comb k = rx_sof ? 3'h0 : cnt;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sh <= '{default: 8'h00};
            wp <= 1'b0;
            wa <= 4'h0;
            cnt <= 3'h0;
            {eq, ones, grp, uni_q, bro_q, grp_q} <= 6'h00;
        end else begin
            wp <= hsel && htrans[1] && hready && hwrite && haddr[7:6] == 2'h0;
            wa <= haddr[5:2];
            if (wp) sh[wa] <= hwdata[7:0];
            if (rx_valid && rx_ready && k < 3'h6) begin
                cnt <= k + 3'h1;
                eq <= (k == 3'h0 || eq) && rx_data == sh[{1'b0, k}];
                ones <= (k == 3'h0 || ones) && rx_data == RAF_ALL_ONES;
                grp <= k == 3'h0 ? rx_data[0] : grp;
                if (k == 3'h5) begin
                    uni_q <= eq && rx_data == sh[5];
                    bro_q <= ones && rx_data == RAF_ALL_ONES;
                    grp_q <= grp;
                end
            end
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    AST_ACCEPT_MIX: assert property (decision_valid |-> final_accept == (match_unicast
        || (cfg[0] && match_broadcast) || (cfg[1] && match_multicast) || cfg[2]))
        else $error("final accept does not follow matches and config");
    AST_UNICAST_BYTES: assert property (decision_valid |-> match_unicast == uni_q)
        else $error("unicast match wrong");
    AST_ALL_ONES: assert property (decision_valid |-> match_broadcast == bro_q)
        else $error("broadcast match wrong");
    AST_GROUP_BIT: assert property (decision_valid && match_multicast |-> grp_q)
        else $error("multicast match without group bit");
    AST_PULSE: assert property (decision_valid |=> !decision_valid)
        else $error("decision pulse too long");
    AST_FLAGS_HOLD: assert property (!decision_valid |-> $stable({match_unicast,
        match_multicast, match_broadcast, final_accept}))
        else $error("flags changed without decision");
    AST_REJECT_SILENT: assert property (decision_valid && !final_accept |=>
        (!(out_valid && out_sof)) [*6])
        else $error("rejected frame started on output");
    AST_ACCEPT_SENDS: assert property (decision_valid && final_accept |->
        ##[1:20] out_valid && out_sof)
        else $error("accepted frame never started");
    AST_READ_WAIT: assert property (hsel && htrans[1] && hready && !hwrite |=>
        !hreadyout ##1 hreadyout)
        else $error("read data phase not one wait cycle");
endmodule

bind raf_filter raf_filter_checker i_chk (.ref_clk, .rst_b, .hsel, .haddr, .htrans, .hwrite,
    .hwdata, .hready, .hreadyout, .rx_valid, .rx_data, .rx_sof, .rx_ready, .out_valid,
    .out_sof, .match_unicast, .match_multicast, .match_broadcast, .final_accept,
    .decision_valid);

//--- tb/raf_rx_source.sv
// Model of the MAC receiver that hands frames to the filter, one byte per handshake.
// Assumes the filter takes a byte on a rising edge with valid and ready both high.
module raf_rx_source (
    // Clock
    input wire logic ref_clk,
    // Frame stream
    input wire logic rx_ready,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_sof,
    output logic rx_eof
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_sof = 1'b0;
        rx_eof = 1'b0;
    end
    // The idle edge after each byte keeps the offered rate at half the clock or below.
    task automatic send(input logic [7:0] fr[$], input int gap);
        foreach (fr[i]) begin
            rx_valid <= 1'b1;
            rx_data <= fr[i];
            rx_sof <= i == 0;
            rx_eof <= i == fr.size() - 1;
            do @(posedge ref_clk); while (rx_ready !== 1'b1);
            rx_valid <= 1'b0;
            rx_data <= ~fr[i];
            repeat (1 + gap) @(posedge ref_clk);
        end
    endtask
endmodule

//--- tb/tb_top.sv
// Self-checking bench of the receive address filter with a scoreboard model.
// Assumes the filter, its fifo, the bound checker and the frame source are compiled.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import raf_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic out_ready = 1'b0;
    logic stall = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [7:0] haddr = 8'h00;
    logic [31:0] hwdata = 32'h0000_0000;
    // Xorshift state, starting at 33097.
    logic [31:0] seed = 32'h0000_8149;
    logic [7:0] n_acc = 8'h00;
    logic [7:0] n_rej = 8'h00;
    logic [3:0] last = 4'h0;
    logic [7:0] regs [16] = '{default: 8'h00};
    logic [3:0] exp_dec[$];
    logic [9:0] exp_out[$];
    logic [47:0] sta;
    logic [31:0] hrdata;
    logic [7:0] rx_data, out_data;
    logic hreadyout, hresp, rx_valid, rx_sof, rx_eof, rx_ready, out_valid, out_sof, out_eof;
    logic match_unicast, match_multicast, match_broadcast, final_accept, decision_valid;
    wire logic [3:0] flags = {final_accept, match_broadcast, match_multicast, match_unicast};
    wire logic [9:0] ob = {out_eof, out_sof, out_data};
    int mismatches = 0;
    int checked = 0;

    raf_filter i_dut (
        .ref_clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .rx_valid, .rx_data, .rx_sof,
        .rx_eof, .rx_ready, .out_valid, .out_data, .out_sof, .out_eof, .out_ready,
        .match_unicast, .match_multicast, .match_broadcast, .final_accept, .decision_valid
    );
    raf_rx_source i_src (.ref_clk, .rx_ready, .rx_valid, .rx_data, .rx_sof, .rx_eof);

    always #2.5 ref_clk = ~ref_clk;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [31:0] rexp(input logic [7:0] a);
        if (a == RAF_OFS_STATUS) return {8'h00, n_rej, n_acc, 4'h0, last};
        if (a < RAF_OFS_STATUS) return {24'h00_0000, regs[a[5:2]]};
        return 32'h0000_0000;
    endfunction

    task automatic compare(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            mismatches++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Every read is checked against the register model.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        compare(32'(hresp), 32'h0000_0000);
        if (!wr) compare(hrdata, rexp(a));
        if (wr && a < RAF_OFS_STATUS) begin
            regs[a[5:2]] = a == RAF_OFS_RX_CONFIG ? 8'(wd[2:0]) : wd[7:0];
        end
    endtask

    task automatic tx(input logic [47:0] da, input int len, input int gap);
        logic [7:0] fr[$];
        logic [31:0] c;
        logic u, b, m, acc;
        c = RAF_CRC_INIT;
        u = 1'b1;
        b = 1'b1;
        for (int i = 0; i < len; i++) fr.push_back(i < 6 ? da[8 * i +: 8] : 8'(rnd()));
        for (int i = 0; i < 48; i++) begin
            c = {c[30:0], 1'b0} ^ ((c[31] ^ da[i]) ? RAF_CRC_POLY : 32'h0000_0000);
        end
        for (int k = 0; k < 6; k++) begin
            u &= da[8 * k +: 8] == regs[k];
            b &= da[8 * k +: 8] == RAF_ALL_ONES;
        end
        m = da[0] && regs[6 + c[31:29]][c[28:26]];
        acc = u || (regs[14][0] && b) || (regs[14][1] && m) || regs[14][2];
        if (len >= 6) begin
            last = {acc, b, m, u};
            exp_dec.push_back(last);
        end
        if (len >= 6 && acc) begin
            n_acc++;
            foreach (fr[i]) exp_out.push_back({i == len - 1, i == 0, fr[i]});
        end else begin
            n_rej++;
        end
        i_src.send(fr, gap);
    endtask

    task automatic drain();
        for (int n = 0; n < 3000 && exp_out.size() + exp_dec.size() > 0; n++) begin
            @(posedge ref_clk);
        end
        compare(32'(exp_out.size() + exp_dec.size()), 32'h0000_0000);
        repeat (4) @(posedge ref_clk);
    endtask

    always @(posedge ref_clk) begin
        out_ready <= !stall && rnd() % 4 != 0;
        if (decision_valid === 1'b1) begin
            compare(32'(flags), exp_dec.size() ? 32'(exp_dec.pop_front()) : 32'hx);
        end
        if (out_valid === 1'b1 && out_ready === 1'b1) begin
            compare(32'(ob), exp_out.size() ? 32'(exp_out.pop_front()) : 32'hx);
        end
    end

    initial begin
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        // Reset value, random write, read back; 0x3c is read only and 0x40 unmapped.
        for (int a = 0; a < 'h44; a += 4) begin
            bus(1'b0, 8'(a), 32'h0000_0000);
            bus(1'b1, 8'(a), rnd());
            bus(1'b0, 8'(a), 32'h0000_0000);
        end
        sta = {16'(rnd()), rnd()};
        for (int k = 0; k < 6; k++) bus(1'b1, 8'(4 * k), 32'(sta[8 * k +: 8]));
        for (int c = 0; c < 8; c++) begin
            drain();
            bus(1'b1, RAF_OFS_RX_CONFIG, 32'(c));
            tx(sta, 8, 0);
            tx(sta ^ 48'h8000_0000_0000, 7, 1);
            tx({48{1'b1}}, 6, 0);
            tx({16'(rnd()), rnd() | 32'h0000_0001}, 9, 2);
            tx({16'(rnd()), rnd() & 32'hffff_fffe}, 8, 0);
            tx(sta, 4, 0);
        end
        drain();
        for (int k = 0; k < 8; k++) bus(1'b1, RAF_OFS_HASH0 + 8'(4 * k), 32'h0000_00ff);
        bus(1'b1, RAF_OFS_RX_CONFIG, 32'h0000_0002);
        repeat (3) tx({16'(rnd()), rnd() | 32'h0000_0001}, 8, 0);
        drain();
        bus(1'b1, RAF_OFS_RX_CONFIG, 32'h0000_0004);
        stall <= 1'b1;
        fork
            tx({16'(rnd()), rnd()}, 20, 0);
            begin
                repeat (60) @(posedge ref_clk);
                compare(32'(rx_ready), 32'h0000_0000);
                stall <= 1'b0;
            end
        join
        drain();
        bus(1'b0, RAF_OFS_STATUS, 32'h0000_0000);
        finish_test();
    end

    // Traffic needs under two thousand cycles; the 40000-cycle limit allows over twenty times that.
    initial begin
        #200_000;
        mismatches++;
        finish_test();
    end
endmodule
